// [hw/setup_bank_pkg.sv]
// Behaviour
// - service time bit 15 clear gives default 6.25 percent, set gives custom time
// - custom field 00..FF means 0.0..25.5 ms in 0.1 ms steps, resets to 00
// - custom value is used only when bit 15 of that word is one at start
// - startup data-load bit set requests data memory load at startup
// - protect bit 0 set rejects programming tool writes to program and setup
// - protection takes effect at power-on or start; removing it acts at once
// - bit 8 suppresses system interrupts in sync mode, sampled at power-on
// - bit 12 clear flags cycles longer than 10 ms; sampled at start
// - input code 0 normal, 1 rising, 2 falling, 3 edge interrupt option
// - four 4-bit input fields in ascending nibbles, sampled at power-on
// - codes 1 to 3 apply in input interrupt mode and in counter mode
// - low byte selects upper two shared words, high byte the lower two
// - selector codes 00..05, 07..09 decode to sources; 06 reserved, 5A gives no source
// - refresh counts 00..19 hex, at most 25 words; 00 disables that area
package setup_bank_pkg;

    localparam longint CLK_FREQ_HZ       = 200_000_000;
    localparam longint SVC_UNIT_US       = 100;
    localparam int     SVC_UNIT_CYCLES   = int'((SVC_UNIT_US * CLK_FREQ_HZ) / 1_000_000);
    localparam longint LONG_CYCLE_MS     = 10;
    localparam int     LONG_CYCLE_CYCLES = int'((LONG_CYCLE_MS * CLK_FREQ_HZ) / 1000);
    localparam int     SVC_W             = 23;

    localparam logic [9:0] IDX_STARTUP_MODE = 10'h052;
    localparam logic [9:0] IDX_SERVICE_TIME = 10'h0da;
    localparam logic [9:0] IDX_MODULE_OPTS  = 10'h130;
    localparam logic [9:0] IDX_IRQ_FUNC     = 10'h131;
    localparam logic [9:0] IDX_SYNC_SELECT  = 10'h132;
    localparam logic [9:0] IDX_REFRESH1     = 10'h135;
    localparam logic [9:0] IDX_REFRESH2     = 10'h136;
    localparam logic [9:0] IDX_IRQ_STATUS   = 10'h200;
    localparam logic [9:0] IDX_IRQ_MASK     = 10'h201;
    localparam logic [9:0] IDX_RUN_CTRL     = 10'h202;
    localparam logic [9:0] IDX_STATE        = 10'h203;

    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [5:0]  RST_IRQ_MASK = 6'h00;

    localparam int SVC_CUSTOM_BIT  = 15;
    localparam int DM_LOAD_BIT     = 15;
    localparam int PROTECT_BIT     = 0;
    localparam int SYNC_BLOCK_BIT  = 8;
    localparam int LONG_OFF_BIT    = 12;
    localparam int RUN_BIT         = 0;
    localparam int POWER_CYCLE_BIT = 1;
    localparam int IRQ_W           = 6;
    localparam int ST_LONG_CYCLE   = 4;
    localparam int ST_TOOL_REJECT  = 5;

    localparam logic [3:0] FUNC_NORMAL = 4'h0;
    localparam logic [3:0] FUNC_RISE   = 4'h1;
    localparam logic [3:0] FUNC_FALL   = 4'h2;
    localparam logic [3:0] FUNC_BOTH   = 4'h3;

    localparam logic [7:0] REFRESH_MAX = 8'h19;

    typedef enum logic [3:0] {
        SRC_LADDER     = 4'h0,
        SRC_COUNTER1   = 4'h1,
        SRC_COUNTER2   = 4'h2,
        SRC_PULSE1     = 4'h3,
        SRC_PULSE2     = 4'h4,
        SRC_ANALOG_IN  = 4'h5,
        SRC_ANALOG_O1  = 4'h7,
        SRC_ANALOG_O2  = 4'h8,
        SRC_INNER_IN   = 4'h9,
        SRC_NONE       = 4'hf
    } sync_src_e;

    // reserved 06 and undefined codes carry no data rather than stale words
    function automatic sync_src_e decode_sync(input logic [7:0] sel);
        case (sel)
            8'h00:   decode_sync = SRC_LADDER;
            8'h01:   decode_sync = SRC_COUNTER1;
            8'h02:   decode_sync = SRC_COUNTER2;
            8'h03:   decode_sync = SRC_PULSE1;
            8'h04:   decode_sync = SRC_PULSE2;
            8'h05:   decode_sync = SRC_ANALOG_IN;
            8'h07:   decode_sync = SRC_ANALOG_O1;
            8'h08:   decode_sync = SRC_ANALOG_O2;
            8'h09:   decode_sync = SRC_INNER_IN;
            default: decode_sync = SRC_NONE;
        endcase
    endfunction

    function automatic logic [4:0] clamp_refresh(input logic [7:0] cnt);
        clamp_refresh = (cnt > REFRESH_MAX) ? REFRESH_MAX[4:0] : cnt[4:0];
    endfunction

endpackage

// [hw/input_edge_irq.sv]
`timescale 1ns/1ps
module input_edge_irq
    import setup_bank_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [3:0]  pin_i,
    input  wire logic [15:0] func_i,
    output logic      [3:0]  event_o
);

    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;

    function automatic logic edge_hit(input logic [3:0] code, input logic now,
                                      input logic was);
        case (code)
            FUNC_RISE: edge_hit = now & ~was;
            FUNC_FALL: edge_hit = ~now & was;
            FUNC_BOTH: edge_hit = now ^ was;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta <= 4'h0;
            sync <= 4'h0;
            prev <= 4'h0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    // no mode gating: the same codes serve interrupt and counter mode
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            event_o <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                event_o[i] <= edge_hit(func_i[4*i +: 4], sync[i], prev[i]);
            end
        end
    end

    a_fall_two_event: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (func_i[11:8] == FUNC_FALL && !sync[2] && prev[2]) |=> event_o[2])
        else $error("falling edge on input 2 did not raise its event");
    a_normal_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (func_i[3:0] == FUNC_NORMAL) |=> !event_o[0])
        else $error("normal input 0 produced an interrupt event");

endmodule

// [hw/cycle_overrun_timer.sv]
`timescale 1ns/1ps
module cycle_overrun_timer
    import setup_bank_pkg::*;
#(
    parameter int unsigned LIMIT = LONG_CYCLE_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic enable_i,
    input  wire logic mark_i,
    output logic      overrun_o
);

    logic [31:0] count;
    logic        fired;

    // one warning per cycle: fired holds until the next cycle mark or until enable_i drops
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count     <= 32'h0000_0000;
            fired     <= 1'b0;
            overrun_o <= 1'b0;
        end else if (!enable_i || mark_i) begin
            count     <= 32'h0000_0000;
            fired     <= 1'b0;
            overrun_o <= 1'b0;
        end else begin
            overrun_o <= 1'b0;
            if (!fired) begin
                if (count == LIMIT[31:0]) begin
                    fired     <= 1'b1;
                    overrun_o <= 1'b1;
                end else begin
                    count <= count + 32'h0000_0001;
                end
            end
        end
    end

    a_overrun_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
        overrun_o |-> $past(count) == LIMIT[31:0] && $past(enable_i))
        else $error("cycle overrun raised before the time limit");

endmodule

// [hw/controller_system_setup_bank.sv]
`timescale 1ns/1ps
module controller_system_setup_bank
    import setup_bank_pkg::*;
#(
    parameter int unsigned LONG_CYCLE_LIMIT = LONG_CYCLE_CYCLES
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic             tool_write_req_i,
    input  wire logic [3:0]       irq_pin_i,
    input  wire logic             cycle_mark_i,
    output logic                  tool_write_grant_o,
    output logic                  tool_write_reject_o,
    output logic                  running_o,
    output logic                  svc_custom_o,
    output logic      [SVC_W-1:0] svc_time_cycles_o,
    output logic                  data_load_req_o,
    output logic                  sync_irq_block_o,
    output sync_src_e             sync_src_upper_o,
    output sync_src_e             sync_src_lower_o,
    output logic      [4:0]       refresh_out1_o,
    output logic      [4:0]       refresh_in1_o,
    output logic      [4:0]       refresh_out2_o,
    output logic      [4:0]       refresh_in2_o,
    output logic                  irq_o
);

    logic [15:0]      startup_mode_word;
    logic [15:0]      peripheral_service_time;
    logic [15:0]      module_options;
    logic [15:0]      interrupt_input_function;
    logic [15:0]      synchronous_data_select;
    logic [15:0]      extended_refresh_area1;
    logic [15:0]      extended_refresh_area2;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic             run_req;
    logic             por_pending;
    logic             protect_eff;
    logic             long_detect_eff;
    logic [15:0]      irq_func_eff;
    logic [3:0]       input_event;
    logic             overrun_event;
    logic             access;
    logic             wr_en;
    logic [9:0]       wr_idx;
    logic             start_evt;
    logic             rd_hit;
    logic [31:0]      rd_word;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [SVC_W-1:0] next_svc_cycles;

    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // one wait state: pready rises in the second access cycle, data registered
    assign access    = psel_i & penable_i & pready_o;
    assign wr_en     = access & pwrite_i & (paddr_i[1:0] == 2'b00);
    assign wr_idx    = paddr_i[11:2];
    assign start_evt = run_req & ~running_o;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr_i[1:0] != 2'b00) begin
            rd_hit = 1'b0;
        end else begin
            case (paddr_i[11:2])
                IDX_STARTUP_MODE: rd_word[15:0] = startup_mode_word;
                IDX_SERVICE_TIME: rd_word[15:0] = peripheral_service_time;
                IDX_MODULE_OPTS:  rd_word[15:0] = module_options;
                IDX_IRQ_FUNC:     rd_word[15:0] = interrupt_input_function;
                IDX_SYNC_SELECT:  rd_word[15:0] = synchronous_data_select;
                IDX_REFRESH1:     rd_word[15:0] = extended_refresh_area1;
                IDX_REFRESH2:     rd_word[15:0] = extended_refresh_area2;
                IDX_IRQ_STATUS:   rd_word[IRQ_W-1:0] = irq_status;
                IDX_IRQ_MASK:     rd_word[IRQ_W-1:0] = irq_mask;
                IDX_RUN_CTRL:     rd_word[RUN_BIT] = run_req;
                IDX_STATE:        rd_word[4:0] = {sync_irq_block_o, long_detect_eff,
                                                  protect_eff, svc_custom_o, running_o};
                default:          rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~rd_hit;
            if (psel_i && penable_i && !pready_o && !pwrite_i) begin
                prdata_o <= rd_word;
            end
        end
    end

    // setup words hold whatever software wrote; each consumer samples at its moment
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            startup_mode_word        <= RST_WORD;
            peripheral_service_time  <= RST_WORD;
            module_options           <= RST_WORD;
            interrupt_input_function <= RST_WORD;
            synchronous_data_select  <= RST_WORD;
            extended_refresh_area1   <= RST_WORD;
            extended_refresh_area2   <= RST_WORD;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_STARTUP_MODE: startup_mode_word        <= pwdata_i[15:0];
                IDX_SERVICE_TIME: peripheral_service_time  <= pwdata_i[15:0];
                IDX_MODULE_OPTS:  module_options           <= pwdata_i[15:0];
                IDX_IRQ_FUNC:     interrupt_input_function <= pwdata_i[15:0];
                IDX_SYNC_SELECT:  synchronous_data_select  <= pwdata_i[15:0];
                IDX_REFRESH1:     extended_refresh_area1   <= pwdata_i[15:0];
                IDX_REFRESH2:     extended_refresh_area2   <= pwdata_i[15:0];
                default:          ;
            endcase
        end
    end

    // power-cycle bit re-runs the power-on sampling with the words kept
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            run_req     <= 1'b0;
            por_pending <= 1'b1;
            running_o   <= 1'b0;
        end else begin
            running_o   <= run_req;
            por_pending <= wr_en && wr_idx == IDX_RUN_CTRL && pwdata_i[POWER_CYCLE_BIT];
            if (wr_en && wr_idx == IDX_RUN_CTRL) begin
                run_req <= pwdata_i[RUN_BIT];
            end
        end
    end

    always_comb begin
        next_svc_cycles = {SVC_W{1'b0}};
        if (peripheral_service_time[SVC_CUSTOM_BIT]) begin
            next_svc_cycles = SVC_W'(peripheral_service_time[7:0] * SVC_UNIT_CYCLES);
        end
    end

    // service time is frozen while running so a mid-run write waits for the next start
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            svc_custom_o      <= 1'b0;
            svc_time_cycles_o <= {SVC_W{1'b0}};
        end else if (start_evt) begin
            svc_custom_o      <= peripheral_service_time[SVC_CUSTOM_BIT];
            svc_time_cycles_o <= next_svc_cycles;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            data_load_req_o  <= 1'b0;
            sync_irq_block_o <= 1'b0;
            irq_func_eff     <= RST_WORD;
        end else begin
            data_load_req_o <= por_pending & startup_mode_word[DM_LOAD_BIT];
            if (por_pending) begin
                sync_irq_block_o <= module_options[SYNC_BLOCK_BIT];
                irq_func_eff     <= interrupt_input_function;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            protect_eff     <= 1'b0;
            long_detect_eff <= 1'b0;
        end else begin
            if (por_pending || start_evt) begin
                protect_eff <= module_options[PROTECT_BIT];
            end else if (!module_options[PROTECT_BIT]) begin
                protect_eff <= 1'b0;
            end
            if (start_evt) begin
                long_detect_eff <= ~module_options[LONG_OFF_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tool_write_grant_o  <= 1'b0;
            tool_write_reject_o <= 1'b0;
        end else begin
            tool_write_grant_o  <= tool_write_req_i & ~protect_eff;
            tool_write_reject_o <= tool_write_req_i & protect_eff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_src_upper_o <= SRC_LADDER;
            sync_src_lower_o <= SRC_LADDER;
            refresh_out1_o   <= 5'h00;
            refresh_in1_o    <= 5'h00;
            refresh_out2_o   <= 5'h00;
            refresh_in2_o    <= 5'h00;
        end else begin
            sync_src_upper_o <= decode_sync(synchronous_data_select[7:0]);
            sync_src_lower_o <= decode_sync(synchronous_data_select[15:8]);
            refresh_out1_o   <= clamp_refresh(extended_refresh_area1[7:0]);
            refresh_in1_o    <= clamp_refresh(extended_refresh_area1[15:8]);
            refresh_out2_o   <= clamp_refresh(extended_refresh_area2[7:0]);
            refresh_in2_o    <= clamp_refresh(extended_refresh_area2[15:8]);
        end
    end

    input_edge_irq u_edge (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (irq_pin_i),
        .func_i   (irq_func_eff),
        .event_o  (input_event)
    );

    cycle_overrun_timer #(
        .LIMIT (LONG_CYCLE_LIMIT)
    ) u_overrun (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .enable_i  (running_o & long_detect_eff),
        .mark_i    (cycle_mark_i),
        .overrun_o (overrun_event)
    );

    // a new event in the clearing cycle survives: set is applied after clear
    always_comb begin
        irq_set                 = {IRQ_W{1'b0}};
        irq_set[3:0]            = input_event;
        irq_set[ST_LONG_CYCLE]  = overrun_event;
        irq_set[ST_TOOL_REJECT] = tool_write_reject_o;
        irq_clr                 = {IRQ_W{1'b0}};
        if (wr_en && wr_idx == IDX_IRQ_STATUS) begin
            irq_clr = pwdata_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_status <= {IRQ_W{1'b0}};
            irq_mask   <= RST_IRQ_MASK;
            irq_o      <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq_o      <= |(irq_status & irq_mask);
            if (wr_en && wr_idx == IDX_IRQ_MASK) begin
                irq_mask <= pwdata_i[IRQ_W-1:0];
            end
        end
    end

    a_svc_held_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (running_o && run_req) |=> $stable(svc_time_cycles_o) && $stable(svc_custom_o))
        else $error("service time changed during operation");

    a_svc_start_map: assert property (@(posedge clk_i) disable iff (!resetn_i)
        start_evt |=> svc_time_cycles_o == ($past(peripheral_service_time[SVC_CUSTOM_BIT])
            ? SVC_W'($past(peripheral_service_time[7:0]) * SVC_UNIT_CYCLES) : {SVC_W{1'b0}}))
        else $error("service time not taken from the word at start");

    a_svc_default: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !svc_custom_o |-> svc_time_cycles_o == {SVC_W{1'b0}})
        else $error("default service time carries a custom value");

    a_tool_reject: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tool_write_req_i && protect_eff) |=> tool_write_reject_o && !tool_write_grant_o
            ##1 irq_status[ST_TOOL_REJECT])
        else $error("protected tool write was not rejected");

    a_unprotect_now: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !module_options[PROTECT_BIT] |=> !protect_eff)
        else $error("protection removal did not act at once");

    a_protect_waits: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!protect_eff && !por_pending && !start_evt) |=> !protect_eff)
        else $error("protection armed outside power-on or start");

    a_sync_block_por: assert property (@(posedge clk_i) disable iff (!resetn_i)
        por_pending |=> sync_irq_block_o == $past(module_options[SYNC_BLOCK_BIT]))
        else $error("sync interrupt block not sampled at power-on");

    a_dm_load_por: assert property (@(posedge clk_i) disable iff (!resetn_i)
        por_pending |=> data_load_req_o == $past(startup_mode_word[DM_LOAD_BIT]))
        else $error("startup data load request mismatch");

    a_long_warn_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        overrun_event |=> irq_status[ST_LONG_CYCLE]
            ##1 (irq_o || !$past(irq_mask[ST_LONG_CYCLE])))
        else $error("cycle overrun did not set the warning flag");

    a_reserved_src: assert property (@(posedge clk_i) disable iff (!resetn_i)
        synchronous_data_select[7:0] == 8'h06 |=> sync_src_upper_o == SRC_NONE)
        else $error("reserved selector decoded to a source");

    a_refresh_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
        extended_refresh_area1[7:0] > REFRESH_MAX |=> refresh_out1_o == REFRESH_MAX[4:0])
        else $error("refresh count exceeds 25 words");

    a_custom_start: assert property (start_evt
        |=> svc_custom_o == $past(peripheral_service_time[SVC_CUSTOM_BIT]))
        else $error("custom bit missed at start");

    a_long_start: assert property (start_evt
        |=> long_detect_eff == !$past(module_options[LONG_OFF_BIT]))
        else $error("long detect missed at start");

    a_long_hold: assert property (!start_evt
        |=> $stable(long_detect_eff))
        else $error("long detect moved while running");

    a_func_por: assert property (por_pending
        |=> irq_func_eff == $past(interrupt_input_function))
        else $error("input functions missed at power-on");

    a_func_hold: assert property (!por_pending
        |=> $stable(irq_func_eff))
        else $error("input functions moved after power-on");

    a_dm_load_idle: assert property (!por_pending
        |=> !data_load_req_o)
        else $error("data load outside power-on");

    a_grant_open: assert property (tool_write_req_i && !protect_eff
        |=> tool_write_grant_o && !tool_write_reject_o)
        else $error("open tool write not granted");

endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import setup_bank_pkg::*;
    typedef struct {logic [9:0] a; logic [31:0] w; logic [31:0] e;} row_s;
    logic             clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic             tool_write_req_i = 0, cycle_mark_i = 0, pready_o, pslverr_o, err;
    logic             tool_write_grant_o, tool_write_reject_o, running_o, svc_custom_o;
    logic             data_load_req_o, sync_irq_block_o, irq_o, seen;
    logic [11:0]      paddr_i = 0;
    logic [31:0]      pwdata_i = 0, prdata_o, rd;
    logic [3:0]       irq_pin_i = 0;
    logic [7:0]       x, y;
    logic [SVC_W-1:0] svc_time_cycles_o;
    sync_src_e        sync_src_upper_o, sync_src_lower_o;
    logic [4:0]       refresh_out1_o, refresh_in1_o, refresh_out2_o, refresh_in2_o;
    int               bad_count = 0, n_checks = 0, cyc = 0;
    logic [7:0]       codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                     8'h07, 8'h08, 8'h09, 8'h5a};
    logic [7:0]       cnts [5] = '{8'h00, 8'h01, 8'h19, 8'h1a, 8'hff};
    row_s             rows [7] = '{
        '{IDX_STARTUP_MODE, 32'hffff_8000, 32'h0000_8000},
        '{IDX_SERVICE_TIME, 32'h0000_80ff, 32'h0000_80ff},
        '{IDX_MODULE_OPTS, 32'h0000_1100, 32'h0000_1100},
        '{IDX_IRQ_FUNC, 32'h0000_3210, 32'h0000_3210},
        '{IDX_SYNC_SELECT, 32'h0000_095a, 32'h0000_095a},
        '{IDX_REFRESH1, 32'h0000_1900, 32'h0000_1900},
        '{IDX_REFRESH2, 32'h0000_0119, 32'h0000_0119}};

    always #2.5 clk_i = ~clk_i;

    // long-cycle limit shortened so an overrun shows within a few dozen cycles
    controller_system_setup_bank #(.LONG_CYCLE_LIMIT(50)) DUT (.clk_i, .resetn_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .tool_write_req_i, .irq_pin_i, .cycle_mark_i, .tool_write_grant_o,
        .tool_write_reject_o, .running_o, .svc_custom_o, .svc_time_cycles_o,
        .data_load_req_o, .sync_irq_block_o, .sync_src_upper_o, .sync_src_lower_o,
        .refresh_out1_o, .refresh_in1_o, .refresh_out2_o, .refresh_in2_o, .irq_o);

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", s, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // entry waits an edge so a strobe released by the last call is never re-driven at once
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= {a, 2'b00};
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string s, input logic [9:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(s, rd, e);
    endtask

    task automatic tool(input logic g, input logic r);
        @(posedge clk_i);
        tool_write_req_i <= 1'b1;
        @(posedge clk_i);
        tool_write_req_i <= 1'b0;
        @(posedge clk_i);
        chk("grant", 32'(tool_write_grant_o), 32'(g));
        chk("reject", 32'(tool_write_reject_o), 32'(r));
    endtask

    function automatic logic [3:0] sx(input logic [7:0] c);
        return (c <= 8'h09 && c != 8'h06) ? c[3:0] : 4'hf;
    endfunction

    function automatic logic [4:0] rx(input logic [7:0] c);
        return (c > 8'h19) ? 5'h19 : c[4:0];
    endfunction

    initial begin
        tick(5);
        resetn_i <= 1'b1;
        tick(2);
        chk("outputs", {running_o, svc_custom_o, irq_o, sync_irq_block_o, svc_time_cycles_o}, 0);
        for (int i = 0; i < 7; i++) begin
            rdchk("reset word", rows[i].a, 32'h0000_0000);
            wr(rows[i].a, rows[i].w);
            rdchk("word", rows[i].a, rows[i].e);
        end
        $display("rows done");
        for (int i = 0; i < 11; i++) begin
            x = codes[i];
            y = codes[(i + 1) % 11];
            wr(IDX_SYNC_SELECT, {16'h0000, x, y});
            tick(2);
            chk("upper src", 32'(sync_src_upper_o), 32'(sx(y)));
            chk("lower src", 32'(sync_src_lower_o), 32'(sx(x)));
        end
        for (int i = 0; i < 5; i++) begin
            x = cnts[i];
            y = ~cnts[i];
            wr(IDX_REFRESH1, {16'h0000, y, x});
            wr(IDX_REFRESH2, {16'h0000, x, y});
            tick(2);
            chk("refresh", {refresh_out1_o, refresh_in1_o, refresh_out2_o, refresh_in2_o},
                {rx(x), rx(y), rx(y), rx(x)});
        end
        $display("decode done");
        apb(1'b0, 10'h3ff, 32'h0000_0000);
        chk("slverr", 32'(err), 1);
        chk("unmapped", rd, 0);
        wr(IDX_RUN_CTRL, 32'h0000_0002);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk_i);
            seen |= data_load_req_o;
        end
        chk("data load", 32'(seen), 1);
        chk("sync block", 32'(sync_irq_block_o), 1);
        chk("custom idle", 32'(svc_custom_o), 0);
        wr(IDX_RUN_CTRL, 32'h0000_0001);
        tick(3);
        chk("custom", {svc_custom_o, svc_time_cycles_o},
            {1'b1, 23'(255 * SVC_UNIT_CYCLES)});
        wr(IDX_SERVICE_TIME, 32'h0000_0005);
        tick(60);
        chk("held", {svc_custom_o, svc_time_cycles_o},
            {1'b1, 23'(255 * SVC_UNIT_CYCLES)});
        rdchk("no overrun", IDX_IRQ_STATUS, 0);
        wr(IDX_MODULE_OPTS, 32'h0000_0001);
        tool(1'b1, 1'b0);
        wr(IDX_RUN_CTRL, 32'h0000_0000);
        wr(IDX_RUN_CTRL, 32'h0000_0001);
        tick(3);
        chk("default", {svc_custom_o, svc_time_cycles_o}, 0);
        rdchk("state", IDX_STATE, 32'h0000_001d);
        tool(1'b0, 1'b1);
        tick(60);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        chk("warn+reject", rd[5:4], 2'b11);
        wr(IDX_IRQ_MASK, 32'h0000_0020);
        tick(2);
        chk("irq", 32'(irq_o), 1);
        wr(IDX_IRQ_STATUS, 32'h0000_0020);
        tick(2);
        chk("irq cleared", 32'(irq_o), 0);
        wr(IDX_MODULE_OPTS, 32'h0000_0000);
        tool(1'b1, 1'b0);
        $display("control done");
        wr(IDX_IRQ_MASK, 32'h0000_000f);
        irq_pin_i <= 4'hf;
        tick(10);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        chk("rise", rd[3:0], 4'ha);
        chk("pin irq", 32'(irq_o), 1);
        wr(IDX_IRQ_STATUS, 32'h0000_000f);
        irq_pin_i <= 4'h0;
        tick(10);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        chk("fall", rd[3:0], 4'hc);
        $display("pins done");
        finish_test();
    end
endmodule
